// ### rtl/usb_device_control_and_irq_status.sv
// Purpose: Control and interrupt status registers of a USB device core
// Assumes: Bus and event inputs on clk; activity pin is asynchronous
// Notes: Low power bit clears without a clock on line activity in suspend
`timescale 1ns/1ps
module usb_device_control_and_irq_status (
   input wire logic clk, // System clock
   input wire logic nrst, // Synchronous reset, active low
   input wire logic sel, // Register access select
   input wire logic wr, // Write strobe
   input wire logic [7:0] addr, // Byte offset
   input wire logic [1:0] size, // 1 half-word, 2 word
   input wire logic [31:0] wdata, // Write data
   output logic [31:0] rdata, // Read data
   input wire logic wakeActivity, // Async line activity pin
   input wire usb_ctrl_pkg::bus_evt_t busEvt, // Protocol events
   input wire usb_ctrl_pkg::fault_t faults, // Protocol errors
   input wire usb_ctrl_pkg::ep_state_t epState, // Endpoint pending bits
   output logic irq, // Shared interrupt request
   output logic epIrq, // Endpoint completion interrupt
   output logic wakeupLine, // Wakeup to rest of device
   output logic suspended, // Suspend mode active
   output logic lowPower, // Transceiver low power
   output logic powerOff, // Analog parts off
   output logic coreReset, // Protocol engine held reset
   output logic resumeDrive, // Send resume to host
   output logic ackInhibit, // Withhold ACK on overrun
   output logic stuffErrForce // Force stuff error on overrun
);
   logic [7:0] maskBits;
   logic resumeBit, sleepBit, powOffBit, fresBit;
   logic [6:0] flags;
   logic doneFlag;
   logic dirBit;
   logic [3:0] epId;
   logic lowPowBit;
   logic lpClrAsync;
   logic lpSet;
   logic actMeta, actSync, actPrev;
   logic [1:0] missCount;
   logic ctlWr, statWr;
   logic wakeEvt, idleEvt, brstEvt, faultEvt;

   function automatic logic [4:0] pickEndpoint(
      input usb_ctrl_pkg::ep_state_t s);
      logic [usb_ctrl_pkg::NUM_EP-1:0] any;
      logic [4:0] res;
      any = s.rxPending | s.txPending;
      res = 5'h00;
      for (int i = usb_ctrl_pkg::NUM_EP - 1; i >= 0; i--) begin
         if (any[i] && !s.isoOrDbl[i]) begin
            res = {1'b1, i[3:0]};
         end
      end
      for (int i = usb_ctrl_pkg::NUM_EP - 1; i >= 0; i--) begin
         if (any[i] && s.isoOrDbl[i]) begin
            res = {1'b1, i[3:0]};
         end
      end
      return res;
   endfunction

   // 16-bit registers; half-word and word both land on the low half
   assign ctlWr = sel && wr && addr == usb_ctrl_pkg::OFS_CONTROL
      && size != 2'h0;
   assign statWr = sel && wr && addr == usb_ctrl_pkg::OFS_STATUS
      && size != 2'h0;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         actMeta <= 1'b0;
         actSync <= 1'b0;
         actPrev <= 1'b0;
      end else begin
         actMeta <= wakeActivity;
         actSync <= actMeta;
         actPrev <= actSync;
      end
   end

   assign wakeEvt = sleepBit && actSync && !actPrev;
   assign brstEvt = busEvt.busReset || fresBit;
   assign faultEvt = |faults;
   // Missed-frame counting runs only outside suspend
   assign idleEvt = !sleepBit && busEvt.frameMissed
      && missCount == usb_ctrl_pkg::MISS_LIMIT - 2'h1;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         missCount <= 2'h0;
      end else if (sleepBit || brstEvt || busEvt.busActivity
            || busEvt.frameStart) begin
         missCount <= 2'h0;
      end else if (busEvt.frameMissed) begin
         missCount <= (missCount == usb_ctrl_pkg::MISS_LIMIT - 2'h1)
            ? 2'h0 : missCount + 2'h1;
      end
   end

   // Control register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         maskBits <= usb_ctrl_pkg::CONTROL_RESET[15:8];
         resumeBit <= usb_ctrl_pkg::CONTROL_RESET[usb_ctrl_pkg::BIT_RESUME];
         sleepBit <= usb_ctrl_pkg::CONTROL_RESET[usb_ctrl_pkg::BIT_SLEEP];
         powOffBit <= usb_ctrl_pkg::CONTROL_RESET[usb_ctrl_pkg::BIT_POWOFF];
         fresBit <= usb_ctrl_pkg::CONTROL_RESET[usb_ctrl_pkg::BIT_FRESET];
      end else if (ctlWr) begin
         maskBits <= wdata[15:8];
         resumeBit <= wdata[usb_ctrl_pkg::BIT_RESUME];
         sleepBit <= wdata[usb_ctrl_pkg::BIT_SLEEP];
         powOffBit <= wdata[usb_ctrl_pkg::BIT_POWOFF];
         fresBit <= wdata[usb_ctrl_pkg::BIT_FRESET];
      end
   end

   // Low power: set by software, cleared async by raw activity
   assign lpClrAsync = wakeActivity && sleepBit;
   assign lpSet = ctlWr && wdata[usb_ctrl_pkg::BIT_LOWPOW];
   always_ff @(posedge clk or posedge lpClrAsync) begin
      if (lpClrAsync) begin
         lowPowBit <= 1'b0;
      end else if (!nrst) begin
         lowPowBit <= usb_ctrl_pkg::CONTROL_RESET[usb_ctrl_pkg::BIT_LOWPOW];
      end else if (ctlWr) begin
         lowPowBit <= lpSet;
      end
   end

   // Event flags: hardware set wins over a write of zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         flags <= usb_ctrl_pkg::STATUS_RESET[14:8];
      end else begin
         for (int i = 0; i < 7; i++) begin
            logic setIt;
            setIt = 1'b0;
            case (i)
               usb_ctrl_pkg::FLG_OVR: setIt = busEvt.memOverrun;
               usb_ctrl_pkg::FLG_FAULT: setIt = faultEvt;
               usb_ctrl_pkg::FLG_WAKE: setIt = wakeEvt;
               usb_ctrl_pkg::FLG_IDLE: setIt = idleEvt;
               usb_ctrl_pkg::FLG_BRST: setIt = brstEvt;
               usb_ctrl_pkg::FLG_SOF: setIt = busEvt.frameStart;
               default: setIt = busEvt.frameMissed;
            endcase
            if (setIt) begin
               flags[i] <= 1'b1;
            end else if (statWr && !wdata[8 + i]) begin
               flags[i] <= 1'b0;
            end
         end
      end
   end

   // Completion report follows endpoint pending bits
   always_ff @(posedge clk) begin
      logic [4:0] pick;
      pick = pickEndpoint(epState);
      if (!nrst) begin
         doneFlag <= 1'b0;
         dirBit <= 1'b0;
         epId <= 4'h0;
      end else begin
         doneFlag <= pick[4];
         if (pick[4]) begin
            epId <= pick[3:0];
            dirBit <= epState.rxPending[pick[2:0]];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq <= 1'b0;
         epIrq <= 1'b0;
      end else begin
         irq <= |({doneFlag, flags} & maskBits);
         epIrq <= |(epState.rxPending | epState.txPending);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wakeupLine <= 1'b0;
         suspended <= 1'b0;
         lowPower <= 1'b0;
         powerOff <= 1'b1;
         coreReset <= 1'b1;
         resumeDrive <= 1'b0;
         ackInhibit <= 1'b0;
         stuffErrForce <= 1'b0;
      end else begin
         wakeupLine <= wakeEvt;
         suspended <= sleepBit;
         lowPower <= lowPowBit && sleepBit;
         powerOff <= powOffBit;
         coreReset <= fresBit || powOffBit;
         resumeDrive <= resumeBit && !powOffBit;
         ackInhibit <= busEvt.memOverrun && busEvt.overrunRx;
         stuffErrForce <= busEvt.memOverrun && !busEvt.overrunRx;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata <= 32'h00000000;
      end else if (sel && !wr) begin
         unique case (addr)
            usb_ctrl_pkg::OFS_CONTROL: rdata <= {16'h0000, maskBits,
               3'h0, resumeBit, sleepBit, lowPowBit, powOffBit,
               fresBit};
            usb_ctrl_pkg::OFS_STATUS: rdata <= {16'h0000, doneFlag,
               flags, 3'h0, dirBit, epId};
            default: rdata <= 32'h00000000;
         endcase
      end
   end

   // Interrupt request from masked flags
   a_mask_gates_irq: assert property (
      @(posedge clk) disable iff (!nrst)
      (maskBits == 8'h00) |=> !irq)
      else $error("irq raised with all masks off");
   a_flag_drives_irq: assert property (
      @(posedge clk) disable iff (!nrst)
      |({doneFlag, flags} & maskBits) |=> irq)
      else $error("enabled flag gave no irq");
   a_irq_only_flags: assert property (
      @(posedge clk) disable iff (!nrst)
      !(|({doneFlag, flags} & maskBits)) |=> !irq)
      else $error("irq without an enabled flag");
   a_ctl_write_masks: assert property (
      @(posedge clk) disable iff (!nrst)
      ctlWr |=> maskBits == $past(wdata[15:8]))
      else $error("mask bits not written");

   // Event flags
   a_flag_write_one: assert property (
      @(posedge clk) disable iff (!nrst)
      (statWr && wdata[13] && flags[5]) |=> flags[5])
      else $error("writing one cleared fault flag");
   a_flag_held_one: assert property (
      @(posedge clk) disable iff (!nrst)
      (statWr && wdata[14:8] == 7'h7F)
      |=> (flags & $past(flags)) == $past(flags))
      else $error("writing ones cleared a flag");
   a_flag_clear_zero: assert property (
      @(posedge clk) disable iff (!nrst)
      (statWr && wdata[14:8] == 7'h00 && !busEvt.memOverrun && !faultEvt
      && !wakeEvt && !idleEvt && !brstEvt && !busEvt.frameStart
      && !busEvt.frameMissed) |=> flags == 7'h00)
      else $error("flags not cleared by zero");
   a_fault_sets_flag: assert property (
      @(posedge clk) disable iff (!nrst)
      faultEvt |=> flags[usb_ctrl_pkg::FLG_FAULT])
      else $error("fault not flagged");
   a_overrun_flag: assert property (
      @(posedge clk) disable iff (!nrst)
      busEvt.memOverrun |=> flags[usb_ctrl_pkg::FLG_OVR])
      else $error("overrun not flagged");
   a_idle_sets_flag: assert property (
      @(posedge clk) disable iff (!nrst)
      idleEvt |=> flags[usb_ctrl_pkg::FLG_IDLE])
      else $error("idle request not flagged");
   a_miss_sets_flag: assert property (
      @(posedge clk) disable iff (!nrst)
      busEvt.frameMissed |=> flags[usb_ctrl_pkg::FLG_MISS])
      else $error("missed frame not flagged");
   a_wake_sets_flag: assert property (
      @(posedge clk) disable iff (!nrst)
      wakeEvt |=> flags[usb_ctrl_pkg::FLG_WAKE] && wakeupLine)
      else $error("wake not flagged");

   // Power, reset and overrun controls
   a_freset_flags_reset: assert property (
      @(posedge clk) disable iff (!nrst)
      fresBit |=> flags[usb_ctrl_pkg::FLG_BRST] && coreReset)
      else $error("force reset not acting as bus reset");
   a_poweroff_holds: assert property (
      @(posedge clk) disable iff (!nrst)
      powOffBit |=> powerOff && coreReset)
      else $error("power off not applied");
   a_sleep_shown: assert property (
      @(posedge clk) disable iff (!nrst)
      1'b1 |=> suspended == $past(sleepBit))
      else $error("suspend output does not follow sleep bit");
   a_lowpow_needs_sleep: assert property (
      @(posedge clk) disable iff (!nrst)
      !sleepBit |=> !lowPower)
      else $error("low power without suspend");
   a_lp_async_clear: assert property (
      @(posedge clk) disable iff (!nrst)
      lpClrAsync |-> !lowPowBit)
      else $error("activity left low power set");
   a_resume_drive: assert property (
      @(posedge clk) disable iff (!nrst)
      (resumeBit && !powOffBit) |=> resumeDrive)
      else $error("resume not driven");
   a_overrun_response: assert property (
      @(posedge clk) disable iff (!nrst)
      busEvt.memOverrun |=> (ackInhibit ^ stuffErrForce))
      else $error("overrun response missing");

   // Endpoint completion report
   a_ep_irq_active: assert property (
      @(posedge clk) disable iff (!nrst)
      (|epState.rxPending) |=> epIrq)
      else $error("endpoint irq missing");
   a_ep_irq_idle: assert property (
      @(posedge clk) disable iff (!nrst)
      (epState.rxPending == '0 && epState.txPending == '0) |=> !epIrq)
      else $error("endpoint irq without pending");
   a_done_follows_ep: assert property (
      @(posedge clk) disable iff (!nrst)
      1'b1 |=> doneFlag == $past(|(epState.rxPending | epState.txPending)))
      else $error("transfer done flag not following endpoints");
   a_dir_for_in: assert property (
      @(posedge clk) disable iff (!nrst)
      (epState.rxPending == '0 && epState.txPending != '0) |=> !dirBit)
      else $error("direction not IN");
   a_dir_receive: assert property (
      @(posedge clk) disable iff (!nrst)
      (epState.rxPending != '0 && epState.txPending == '0) |=> dirBit)
      else $error("direction not OUT");

   // Register read data
   a_ctl_reserved: assert property (
      @(posedge clk) disable iff (!nrst)
      (sel && !wr && addr == usb_ctrl_pkg::OFS_CONTROL)
      |=> rdata[31:16] == 16'h0000 && rdata[7:5] == 3'h0)
      else $error("control reserved bits not zero");
   a_sts_reserved: assert property (
      @(posedge clk) disable iff (!nrst)
      (sel && !wr && addr == usb_ctrl_pkg::OFS_STATUS)
      |=> rdata[31:16] == 16'h0000 && rdata[7:5] == 3'h0)
      else $error("status reserved bits not zero");
   a_unmapped_zero: assert property (
      @(posedge clk) disable iff (!nrst)
      (sel && !wr && addr != usb_ctrl_pkg::OFS_CONTROL
      && addr != usb_ctrl_pkg::OFS_STATUS) |=> rdata == 32'h00000000)
      else $error("unmapped read not zero");

   // Main scenarios
   c_irq_raised: cover property (@(posedge clk) disable iff (!nrst)
      !irq ##1 irq);
   c_idle_request: cover property (@(posedge clk) disable iff (!nrst)
      idleEvt);
   c_wake_event: cover property (@(posedge clk) disable iff (!nrst)
      wakeEvt);
   c_overrun_rx: cover property (@(posedge clk) disable iff (!nrst)
      busEvt.memOverrun && busEvt.overrunRx);
   c_ep_done: cover property (@(posedge clk) disable iff (!nrst)
      doneFlag && irq);
endmodule // usb_device_control_and_irq_status

// ### rtl/usb_ctrl_pkg.sv
// Purpose: Constants and types for the USB device control and status block
// Assumes: 125 MHz system clock, 16-bit registers on 32-bit word boundaries
// Notes: Offsets are byte offsets from the peripheral base
// How it works
// - Control bits 15..8 hold eight interrupt masks
// - Mask one lets its flag request interrupt
// - Control resets to 0x0003, low five controls
// - Idle 3 ms raises request; software sets sleep
// - Force sleep enters suspend; low power separate
// - Activity in suspend clears low power asynchronously
// - Power off disconnects transceiver, peripheral halted
// - Force reset acts as bus reset, raises flag
// - Status resets zero; flags, direction, endpoint field
// - Enabled flags share one interrupt request
// - Request stays while enabled flag remains set
// - Flags 14..8 cleared by writing zero only
// - Transfer done flag read-only, follows endpoint pending
// - Endpoint completion condition ignores transfer mask
// - Direction and endpoint field name highest-priority pending endpoint
// - Overrun sets flag; withholds ACK on receive, else forces stuff error
// - Fault flag set by four error kinds
// - Sixteen-bit registers, half-word or word access
// - Offsets from 0x40005C00; packet memory at 0x40006000
// - Direction zero for IN, one when receive pending
// - Isochronous endpoints first, then lowest number wins
// - Wake flag on suspend activity, clears low power
// - Missed frame flag; three misses raise idle request
package usb_ctrl_pkg;
   localparam logic [31:0] PERIPH_BASE = 32'h40005C00;
   localparam logic [31:0] PACKET_MEM_BASE = 32'h40006000;
   localparam logic [7:0] OFS_CONTROL = 8'h40;
   localparam logic [7:0] OFS_STATUS = 8'h44;
   localparam logic [15:0] CONTROL_RESET = 16'h0003;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] CONTROL_WMASK = 16'hFF1F;
   localparam int BIT_RESUME = 4;
   localparam int BIT_SLEEP = 3;
   localparam int BIT_LOWPOW = 2;
   localparam int BIT_POWOFF = 1;
   localparam int BIT_FRESET = 0;
   localparam int FLG_DONE = 7;
   localparam int FLG_OVR = 6;
   localparam int FLG_FAULT = 5;
   localparam int FLG_WAKE = 4;
   localparam int FLG_IDLE = 3;
   localparam int FLG_BRST = 2;
   localparam int FLG_SOF = 1;
   localparam int FLG_MISS = 0;
   localparam int BIT_DIR = 4;
   localparam logic [1:0] MISS_LIMIT = 2'h3;
   localparam int NUM_EP = 8;

   typedef struct packed {
      logic hostTimeout;
      logic crcFault;
      logic bitStuffFault;
      logic framingViolation;
   } fault_t;

   typedef struct packed {
      logic frameStart;
      logic frameMissed;
      logic busReset;
      logic busActivity;
      logic memOverrun;
      logic overrunRx;
   } bus_evt_t;

   typedef struct packed {
      logic [NUM_EP-1:0] rxPending;
      logic [NUM_EP-1:0] txPending;
      logic [NUM_EP-1:0] isoOrDbl;
   } ep_state_t;
endpackage

// ### testbench/usb_host_model.sv
// Purpose: Host side stand-in sending bus events and errors
// Assumes: Requests arrive just after a clk edge, one cycle wide
// Notes: Activity pin moves off the clock grid
`timescale 1ns/1ps
module usb_host_model (
   input wire logic clk, // System clock
   input wire logic [9:0] req, // Events 9..4, errors 3..0
   input wire logic wakeReq, // Resume signalling
   output usb_ctrl_pkg::bus_evt_t busEvt, // Events to device
   output usb_ctrl_pkg::fault_t faults, // Errors to device
   output logic wakeActivity // Line activity
);
   always_ff @(posedge clk) begin
      busEvt <= usb_ctrl_pkg::bus_evt_t'(req[9:4]);
      faults <= usb_ctrl_pkg::fault_t'(req[3:0]);
   end
   assign #3 wakeActivity = wakeReq;
endmodule // usb_host_model

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the USB control and status block
// Assumes: Host model sends events one cycle after each request
// Notes: Millisecond resume timing is not exercised
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] CTL = usb_ctrl_pkg::OFS_CONTROL;
   localparam logic [7:0] STS = usb_ctrl_pkg::OFS_STATUS;
   logic clk, nrst, sel, wr, wakeReq, wakeActivity, irq, epIrq;
   logic wakeupLine, suspended, lowPower, powerOff, coreReset;
   logic resumeDrive, ackInhibit, stuffErrForce;
   logic [7:0] addr;
   logic [1:0] size;
   logic [31:0] wdata, rdata;
   logic [9:0] req;
   usb_ctrl_pkg::bus_evt_t busEvt;
   usb_ctrl_pkg::fault_t faults;
   usb_ctrl_pkg::ep_state_t epState;
   int nFail = 0, totalChecks = 0, nAck = 0, nStuff = 0, nWake = 0;
   logic [9:0] stim [8] = '{10'h030, 10'h020, 10'h008, 10'h004,
                            10'h002, 10'h001, 10'h080, 10'h200};
   int bitOf [8] = '{14, 14, 13, 13, 13, 13, 10, 9};
   usb_device_control_and_irq_status usb_device_control_and_irq_status_inst (
      .clk(clk), .nrst(nrst), .sel(sel), .wr(wr), .addr(addr),
      .size(size), .wdata(wdata), .rdata(rdata),
      .wakeActivity(wakeActivity), .busEvt(busEvt), .faults(faults),
      .epState(epState), .irq(irq), .epIrq(epIrq),
      .wakeupLine(wakeupLine), .suspended(suspended),
      .lowPower(lowPower), .powerOff(powerOff), .coreReset(coreReset),
      .resumeDrive(resumeDrive), .ackInhibit(ackInhibit),
      .stuffErrForce(stuffErrForce));
   usb_host_model usb_host_model_inst (
      .clk(clk), .req(req), .wakeReq(wakeReq), .busEvt(busEvt),
      .faults(faults), .wakeActivity(wakeActivity));
   always #4 clk = ~clk;
   always @(posedge clk) begin
      if (ackInhibit === 1'b1) nAck++;
      if (stuffErrForce === 1'b1) nStuff++;
      if (wakeupLine === 1'b1) nWake++;
   end
   task automatic check(input string n, input logic [31:0] s, e);
      totalChecks++;
      if (s !== e) begin
         nFail++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic results();
      $display("Checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Entered just after an edge; one access then one idle cycle
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
      sel = 1;
      wr = w;
      addr = a;
      size = 2'($urandom_range(2, 1));
      wdata = {16'($urandom), d};
      @(posedge clk);
      #1;
      sel = 0;
      wr = 0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e,
                     input string n);
      acc(0, a, 16'h0000);
      check(n, rdata, {16'h0000, e});
   endtask
   task automatic ev(input logic [9:0] r);
      req = r;
      @(posedge clk);
      #1;
      req = '0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   function automatic logic [15:0] epExp(usb_ctrl_pkg::ep_state_t s);
      logic [7:0] p;
      int k;
      p = s.rxPending | s.txPending;
      k = 0;
      for (int i = 7; i >= 0; i--) if (p[i]) k = i;
      for (int i = 7; i >= 0; i--) if (p[i] && s.isoOrDbl[i]) k = i;
      return {1'b1, 10'h000, s.rxPending[k], 4'(k)};
   endfunction
   initial begin
      clk = 0;
      nrst = 0;
      sel = 0;
      wr = 0;
      addr = 8'h00;
      size = 2'h2;
      wdata = 32'h00000000;
      req = '0;
      wakeReq = 0;
      epState = '0;
      void'($urandom(32'h5E8D));
      repeat (16) @(posedge clk);
      #1;
      nrst = 1;
      rd(STS, 16'h0000, "status reset");
      rd(CTL, usb_ctrl_pkg::CONTROL_RESET, "control reset");
      check("powerOff", powerOff, 1);
      check("coreReset", coreReset, 1);
      rd(STS, 16'h0400, "forced reset flag");
      check("irq masked", irq, 0);
      acc(1, CTL, 16'hFFFF);
      rd(CTL, 16'hFF1F, "control bits");
      check("sleep", {resumeDrive, suspended, lowPower}, 3);
      acc(1, CTL, 16'hFF00);
      acc(1, STS, 16'h0000);
      check("released", {powerOff, coreReset}, 0);
      acc(1, STS, 16'hFFFF);
      rd(STS, 16'h0000, "ones written");
      $display("Test registers done");
      for (int i = 0; i < 8; i++) begin
         ev(stim[i]);
         rd(STS, 16'(1 << bitOf[i]), "event flag");
         check("irq raised", irq, 1);
         acc(1, STS, ~16'(1 << bitOf[i]));
         check("irq dropped", irq, 0);
      end
      check("ack withheld", nAck, 1);
      check("stuff forced", nStuff, 1);
      acc(1, CTL, 16'h0100);
      ev(10'h200);
      check("frame masked", irq, 0);
      acc(1, CTL, 16'h0200);
      check("frame enabled", irq, 1);
      ev(10'h100);
      ev(10'h200);
      ev(10'h100);
      ev(10'h100);
      rd(STS, 16'h0300, "two misses");
      ev(10'h100);
      rd(STS, 16'h0B00, "idle request");
      $display("Test events done");
      // Resume is held far shorter than a bus needs; only the bit is seen
      acc(1, CTL, 16'h101C);
      acc(1, STS, 16'h0000);
      check("low power", {resumeDrive, suspended, lowPower}, 7);
      #2;
      wakeReq = 1;
      repeat (6) @(posedge clk);
      #1;
      check("lp cleared", lowPower, 0);
      check("wake line", nWake, 1);
      check("wake irq", irq, 1);
      rd(STS, 16'h1000, "wake flag");
      rd(CTL, 16'h1018, "after wake");
      wakeReq = 0;
      acc(1, CTL, 16'h0000);
      acc(1, STS, 16'h0000);
      $display("Test wake done");
      for (int i = 0; i < 24; i++) begin
         epState = usb_ctrl_pkg::ep_state_t'(24'($urandom));
         if (i == 0) epState = '1;
         epState.txPending[7] = 1'b1;
         acc(1, CTL, {i[0], 15'h0000});
         rd(STS, epExp(epState), "endpoint id");
         check("ep irq", epIrq, 1);
         check("done irq", irq, i[0]);
      end
      epState = '0;
      acc(1, CTL, 16'h0000);
      check("ep idle", epIrq, 0);
      rd(8'h48, 16'h0000, "unmapped");
      $display("Test endpoints done");
      results();
   end
   initial begin
      #200000;
      nFail++;
      results();
   end
endmodule // tb_top
